// File: hdl/tmr_core.sv
// 8-bit timer/counter core with two compare channels and an APB register file
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_core import tmr_pkg::*; (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`TMR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Oscillator pins
  input  wire logic                  osc_pin_in,
  output logic                       osc_pin_out,
  // Waveform outputs
  output logic                       wave_out_a,
  output logic                       wave_out_b,
  // Interrupt requests and service acknowledges (ovf, a, b)
  output logic      [2:0]            irq,
  input  wire logic [2:0]            irq_ack
);
  // Register state
  tmr_byte_t  ctrl_a_q;
  logic [3:0] ctrl_b_q;
  tmr_byte_t  count_value_q;
  tmr_byte_t  cmp_buf_q [2];
  tmr_byte_t  cmp_act_q [2];
  logic [2:0] timer_mask_reg_q;
  logic [2:0] timer_flag_reg_q;
  logic       async_clock_select_q;
  logic       block_q;
  tmr_dir_t   dir_q;
  logic       oc_q [2];
  logic [2:0] irq_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // Bus decode
  logic       setup_ph;
  logic       wr_en;
  logic       we_ctrl_a, we_ctrl_b, we_count, we_cmp_a, we_cmp_b;
  logic       we_mask, we_flag, we_async;
  logic       addr_hit;
  logic [31:0] rd_data;

  // Counter decode
  logic [2:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic       timer_tick;
  logic       pwm_mode, fast_mode, pc_mode, ctc_mode, top_is_cmp;
  tmr_byte_t  top_val;
  logic       at_top, at_bot, at_max;
  tmr_byte_t  count_next;
  tmr_dir_t   dir_next;
  logic       ovf_set;
  logic       buf_load;
  logic       bot_event;
  logic [1:0] hit;
  logic [1:0] force_match_strobe;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [2:0] flag_d;

  assign setup_ph  = psel & ~penable;
  assign wr_en     = psel & penable & pready_q & pwrite;
  assign we_ctrl_a = wr_en & (paddr == `TMR_ADDR_CTRL_A);
  assign we_ctrl_b = wr_en & (paddr == `TMR_ADDR_CTRL_B);
  assign we_count  = wr_en & (paddr == `TMR_ADDR_COUNT);
  assign we_cmp_a  = wr_en & (paddr == `TMR_ADDR_CMP_A);
  assign we_cmp_b  = wr_en & (paddr == `TMR_ADDR_CMP_B);
  assign we_mask   = wr_en & (paddr == `TMR_ADDR_MASK);
  assign we_flag   = wr_en & (paddr == `TMR_ADDR_FLAG);
  assign we_async  = wr_en & (paddr == `TMR_ADDR_ASYNC);
  assign addr_hit  = (paddr == `TMR_ADDR_CTRL_A) | (paddr == `TMR_ADDR_CTRL_B) |
                     (paddr == `TMR_ADDR_COUNT)  | (paddr == `TMR_ADDR_CMP_A) |
                     (paddr == `TMR_ADDR_CMP_B)  | (paddr == `TMR_ADDR_MASK) |
                     (paddr == `TMR_ADDR_FLAG)   | (paddr == `TMR_ADDR_ASYNC);

  // buffered view on reads
  // Buffer is written in every mode, so it always equals what software last wrote
  assign rd_data =
    (paddr == `TMR_ADDR_CTRL_A) ? {24'h000000, ctrl_a_q} :
    (paddr == `TMR_ADDR_CTRL_B) ? {28'h0000000, ctrl_b_q} :
    (paddr == `TMR_ADDR_COUNT)  ? {24'h000000, count_value_q} :
    (paddr == `TMR_ADDR_CMP_A)  ? {24'h000000, cmp_buf_q[0]} :
    (paddr == `TMR_ADDR_CMP_B)  ? {24'h000000, cmp_buf_q[1]} :
    (paddr == `TMR_ADDR_MASK)   ? {29'h00000000, timer_mask_reg_q} :
    (paddr == `TMR_ADDR_FLAG)   ? {29'h00000000, timer_flag_reg_q} :
    (paddr == `TMR_ADDR_ASYNC)  ? {31'h00000000, async_clock_select_q} : 32'h00000000;

  // mode field split over two registers
  assign waveform_mode_field = {ctrl_b_q[`TMR_WGM2_BIT], ctrl_a_q[`TMR_WGM_LO_HI:0]};
  assign clock_select_field  = ctrl_b_q[`TMR_CS_HI:0];
  assign pwm_mode   = waveform_mode_field[0];
  assign fast_mode  = waveform_mode_field[1] & waveform_mode_field[0];
  assign pc_mode    = ~waveform_mode_field[1] & waveform_mode_field[0];
  assign ctc_mode   = (waveform_mode_field == `TMR_WGM_CTC);
  assign top_is_cmp = (waveform_mode_field[2] & pwm_mode) | ctc_mode;

  assign top_val = top_is_cmp ? cmp_act_q[0] : `TMR_MAX;
  assign at_top  = (count_value_q == top_val);
  assign at_bot  = (count_value_q == `TMR_BOTTOM);
  assign at_max  = (count_value_q == `TMR_MAX);

  // clear at top in clear-on-match and fast modes: compare A, or max in fast mode 3
  always_comb begin
    dir_next   = dir_q;
    count_next = count_value_q + 8'h01;
    if (ctc_mode | fast_mode) begin
      if (at_top) begin
        count_next = `TMR_BOTTOM;
      end
    end else if (pc_mode) begin
      if (dir_q == TMR_UP) begin
        if (at_top) begin
          dir_next   = TMR_DOWN;
          count_next = count_value_q - 8'h01;
        end
      end else if (at_bot) begin
        dir_next = TMR_UP;
      end else begin
        count_next = count_value_q - 8'h01;
      end
    end
  end

  // normal wrap sets overflow
  // Phase-correct overflows at bottom, fast at top, the others on the wrap from max
  assign ovf_set = timer_tick & (pc_mode ? ((dir_q == TMR_DOWN) & at_bot) :
                                 fast_mode ? at_top : at_max);
  assign buf_load  = pwm_mode & timer_tick & at_top;
  assign bot_event = fast_mode & timer_tick & at_top;

  tmr_clk_sel u_clk_sel (
    .pclk        (pclk),
    .presetn     (presetn),
    .async_sel   (async_clock_select_q),
    .clk_sel     (clock_select_field),
    .osc_pin_in  (osc_pin_in),
    .osc_pin_out (osc_pin_out),
    .tick        (timer_tick)
  );

  // APB answer: zero wait states, data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~addr_hit;
      prdata_q  <= setup_ph & ~pwrite ? rd_data : prdata_q;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q             <= `TMR_RST_BYTE;
      ctrl_b_q             <= `TMR_RST_NIB;
      timer_mask_reg_q     <= `TMR_RST_FLAGS;
      async_clock_select_q <= 1'b0;
    end else begin
      if (we_ctrl_a) ctrl_a_q <= pwdata[7:0];
      if (we_ctrl_b) ctrl_b_q <= pwdata[3:0];
      if (we_mask) timer_mask_reg_q <= pwdata[2:0];
      if (we_async) async_clock_select_q <= pwdata[`TMR_ASYNC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= `TMR_BOTTOM;
      dir_q         <= TMR_UP;
    end else if (we_count) begin
      count_value_q <= pwdata[7:0];
    end else if (timer_tick) begin
      count_value_q <= count_next;
      dir_q         <= dir_next;
    end
  end

  // block until next tick
  // Held across a stopped timer so the first tick after enable is still blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q <= 1'b0;
    end else begin
      block_q <= we_count | (block_q & ~timer_tick);
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic       we_cmp;
      logic [1:0] compare_output_mode;
      logic       match;
      logic       oc_d;

      assign we_cmp = ch == 0 ? we_cmp_a : we_cmp_b;
      assign compare_output_mode = ctrl_a_q[`TMR_COM_A_HI - 2 * ch -: 2];
      assign match   = (count_value_q == cmp_act_q[ch]);
      // match counted on the next tick
      assign hit[ch] = timer_tick & match & ~block_q;
      assign force_match_strobe[ch] = we_ctrl_b & pwdata[`TMR_FOC_A_BIT - ch] & ~pwm_mode;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_buf_q[ch] <= `TMR_RST_BYTE;
          cmp_act_q[ch] <= `TMR_RST_BYTE;
        end else begin
          if (we_cmp) cmp_buf_q[ch] <= pwdata[7:0];
          if (we_cmp & ~pwm_mode) cmp_act_q[ch] <= pwdata[7:0];
          else if (buf_load) cmp_act_q[ch] <= cmp_buf_q[ch];
        end
      end

      always_comb begin
        oc_d = oc_q[ch];
        if (hit[ch] | force_match_strobe[ch]) begin
          if (!pwm_mode) begin
            case (compare_output_mode)
              `TMR_COM_TOGGLE: oc_d = ~oc_q[ch];
              `TMR_COM_CLEAR:  oc_d = 1'b0;
              `TMR_COM_SET:    oc_d = 1'b1;
              default:         oc_d = oc_q[ch];
            endcase
          end else if (compare_output_mode[1]) begin
            oc_d = compare_output_mode[0] ^ (pc_mode & (dir_q == TMR_DOWN));
          end else if (compare_output_mode[0] & (ch == 0) &
                       (waveform_mode_field == `TMR_WGM_FAST_A)) begin
            oc_d = ~oc_q[ch];
          end
        end
        // Bottom wins so a compare equal to top gives a steady level
        if (bot_event & compare_output_mode[1]) begin
          oc_d = ~compare_output_mode[0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oc_q[ch] <= 1'b0;
        end else begin
          oc_q[ch] <= oc_d;
        end
      end
    end
  endgenerate

  // clear by service or written one
  assign flag_set = {hit[1], hit[0], ovf_set};
  assign flag_clr = (we_flag ? pwdata[2:0] : 3'h0) | irq_ack;
  // Set beats clear in one cycle
  assign flag_d   = (timer_flag_reg_q & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flag_reg_q <= `TMR_RST_FLAGS;
      irq_q            <= `TMR_RST_FLAGS;
    end else begin
      timer_flag_reg_q <= flag_d;
      irq_q            <= timer_flag_reg_q & timer_mask_reg_q;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign wave_out_a = oc_q[0];
  assign wave_out_b = oc_q[1];
  assign irq        = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cnt_write_prio: assert property (we_count |=> count_value_q == $past(pwdata[7:0]))
    else $error("counter write lost");
  a_stop_no_tick: assert property (clock_select_field == 3'h0 |=> !timer_tick)
    else $error("tick while stopped");
  a_stop_hold_cnt: assert property (!timer_tick && !we_count |=> $stable(count_value_q))
    else $error("counter moved without tick");
  a_match_flag_set: assert property (hit[0] |=> timer_flag_reg_q[`TMR_FLAG_A])
    else $error("match flag not set");
  a_block_after_wr: assert property (we_count |=> !hit[0] && !hit[1])
    else $error("match after counter write");
  a_flag_clear_one: assert property (we_flag && pwdata[`TMR_FLAG_A] && !hit[0]
    |=> !timer_flag_reg_q[`TMR_FLAG_A])
    else $error("flag not cleared by one");
  a_flag_keep_zero: assert property (we_flag && !pwdata[`TMR_FLAG_A] && !irq_ack[1]
    && timer_flag_reg_q[`TMR_FLAG_A] |=> timer_flag_reg_q[`TMR_FLAG_A])
    else $error("flag cleared by zero");
  a_irq_gated: assert property (irq[0] |-> $past(timer_flag_reg_q[0] && timer_mask_reg_q[0]))
    else $error("unmasked interrupt");
  a_ovf_normal: assert property (timer_tick && !we_count && at_max
    && waveform_mode_field == `TMR_WGM_NORMAL
    |=> count_value_q == `TMR_BOTTOM && timer_flag_reg_q[`TMR_FLAG_OVF])
    else $error("normal wrap without overflow");
  a_cmp_bypass: assert property (we_cmp_a && !pwm_mode |=> cmp_act_q[0] == $past(pwdata[7:0]))
    else $error("compare not written directly");
  a_force_no_flag: assert property (force_match_strobe[0] && !hit[0] && !timer_flag_reg_q[1]
    |=> !timer_flag_reg_q[`TMR_FLAG_A])
    else $error("force set match flag");
  a_com_zero_hold: assert property (ctrl_a_q[`TMR_COM_A_HI -: 2] == 2'h0 && !bot_event
    |=> $stable(wave_out_a))
    else $error("output moved with mode zero");
  a_ctc_clear: assert property (ctc_mode && timer_tick && !we_count && at_top
    |=> count_value_q == `TMR_BOTTOM)
    else $error("clear on match missing");

  c_overflow: cover property (ovf_set);
  c_match_a:  cover property (hit[0] ##1 irq[`TMR_FLAG_A]);
  c_buf_load: cover property (we_cmp_a && pwm_mode ##[1:300] buf_load);
  c_force:    cover property (force_match_strobe[1]);
endmodule
`default_nettype wire

// File: common/tmr_defs.svh
// Register map, field positions and reset values of the 8-bit timer core
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_ADDR_W      8
`define TMR_ADDR_CTRL_A 8'h00
`define TMR_ADDR_CTRL_B 8'h04
`define TMR_ADDR_COUNT  8'h08
`define TMR_ADDR_CMP_A  8'h0C
`define TMR_ADDR_CMP_B  8'h10
`define TMR_ADDR_MASK   8'h14
`define TMR_ADDR_FLAG   8'h18
`define TMR_ADDR_ASYNC  8'h1C

`define TMR_COM_A_HI    7
`define TMR_COM_B_HI    5
`define TMR_WGM_LO_HI   1
`define TMR_FOC_A_BIT   7
`define TMR_WGM2_BIT    3
`define TMR_CS_HI       2
`define TMR_ASYNC_BIT   0
`define TMR_FLAG_OVF    0
`define TMR_FLAG_A      1

`define TMR_BOTTOM      8'h00
`define TMR_MAX         8'hFF
`define TMR_RST_BYTE    8'h00
`define TMR_RST_NIB     4'h0
`define TMR_RST_FLAGS   3'h0
`define TMR_WGM_NORMAL  3'h0
`define TMR_WGM_CTC     3'h2
`define TMR_WGM_FAST_A  3'h7
`define TMR_COM_TOGGLE  2'h1
`define TMR_COM_CLEAR   2'h2
`define TMR_COM_SET     2'h3

`define TMR_PRE_W       10
`define TMR_MSK_DIV8    10'h007
`define TMR_MSK_DIV32   10'h01F
`define TMR_MSK_DIV64   10'h03F
`define TMR_MSK_DIV128  10'h07F
`define TMR_MSK_DIV256  10'h0FF
`define TMR_MSK_DIV1024 10'h3FF
`define TMR_MSK_DIV1    10'h000

`endif

// File: common/tmr_pkg.sv
// Types shared by the timer core files
package tmr_pkg;
  typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_t;
  typedef logic [7:0] tmr_byte_t;
endpackage

// File: hdl/tmr_clk_sel.sv
// Timer clock source selection and prescaler, producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_clk_sel import tmr_pkg::*; (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Selection
  input  wire logic       async_sel,
  input  wire logic [2:0] clk_sel,
  // Oscillator pins
  input  wire logic       osc_pin_in,
  output logic            osc_pin_out,
  // Timer tick
  output logic            tick
);
  logic                  sync1_q, sync2_q, sync3_q;
  logic [`TMR_PRE_W-1:0] pre_q;
  logic [`TMR_PRE_W-1:0] tap_mask;
  logic                  src_pulse;
  logic                  tick_d;

  // source select
  // Oscillator edges are counted on the bus clock, so it must run faster than the crystal
  assign src_pulse = async_sel ? (sync2_q & ~sync3_q) : 1'b1;
  assign tap_mask = (clk_sel == 3'h2) ? `TMR_MSK_DIV8 :
                    (clk_sel == 3'h3) ? `TMR_MSK_DIV32 :
                    (clk_sel == 3'h4) ? `TMR_MSK_DIV64 :
                    (clk_sel == 3'h5) ? `TMR_MSK_DIV128 :
                    (clk_sel == 3'h6) ? `TMR_MSK_DIV256 :
                    (clk_sel == 3'h7) ? `TMR_MSK_DIV1024 : `TMR_MSK_DIV1;
  assign tick_d = (clk_sel != 3'h0) & src_pulse & ((pre_q & tap_mask) == tap_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      sync3_q     <= 1'b0;
      pre_q       <= '0;
      tick        <= 1'b0;
      osc_pin_out <= 1'b1;
    end else begin
      sync1_q     <= osc_pin_in;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      pre_q       <= src_pulse ? pre_q + 1'b1 : pre_q;
      tick        <= tick_d;
      osc_pin_out <= ~sync2_q;
    end
  end

  // crystal edge drives the tick
  // Checked against the synchroniser itself, so a miswired source select still trips it
  a_async_edge_tick: assert property (@(posedge pclk) disable iff (!presetn)
    async_sel && !(sync2_q && !sync3_q) |=> !tick)
    else $error("tick without crystal edge");
endmodule
`default_nettype wire

// File: verif/tmr_core_bench.sv
// Self-checking bench for the timer core: APB master, read-result queue and output checks
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_core_bench import tmr_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, osc_pin_in;
  logic        osc_pin_out, pready, pslverr, wave_out_a, wave_out_b, quiet;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [2:0]  irq, irq_ack;
  integer      n_errors, n_tests, seed;
  logic [32:0] exp_q[$];
  string       name_q[$];
  logic [7:0]  ra[5] = '{`TMR_ADDR_COUNT, `TMR_ADDR_CMP_A, `TMR_ADDR_CMP_B, `TMR_ADDR_MASK,
                         `TMR_ADDR_ASYNC};
  logic [7:0]  rm[5] = '{8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h01};
  logic [1:0]  com_seq[4] = '{2'h3, 2'h0, 2'h2, 2'h1};
  logic        wav_seq[4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  tmr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq(irq), .irq_ack(irq_ack));

  initial begin
    pclk = 1'b0;
  end
  always #2.5 pclk = ~pclk;

  // Crystal input wanders randomly so the synchroniser is never idle
  always @(posedge pclk) begin
    osc_pin_in <= 1'($random(seed));
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read results carry {pslverr, prdata} and are judged against the oldest note
  always @(posedge pclk) begin
    if (quiet !== 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0) begin
      if (exp_q.size() == 0)
        chk("unrequested read", 33'h0, 33'h1);
      else
        chk(name_q.pop_front(), exp_q.pop_front(), {pslverr, prdata});
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    integer n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input string what);
    logic [31:0] q;
    exp_q.push_back(e);
    name_q.push_back(what);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Read whose value is judged by the caller, kept off the result queue
  task automatic peek(input logic [7:0] a, output logic [31:0] q);
    quiet <= 1'b1;
    xfer(1'b0, a, 32'h0, q);
    quiet <= 1'b0;
  endtask

  // Clock select 1 ticks every cycle, or on each rising crystal edge with async select; stop again after c cycles
  task automatic run(input integer c);
    wr(`TMR_ADDR_CTRL_B, 32'h1);
    repeat (c) @(posedge pclk);
    wr(`TMR_ADDR_CTRL_B, 32'h0);
  endtask

  task automatic wait_irq(input integer i);
    integer n;
    n = 0;
    while (irq[i] !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("irq line", 33'h1, {32'h0, irq[i]});
    if (irq[i] !== 1'b1)
      wrap_up();
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    $display("CHECK FAILED run length expected finish seen hang");
    wrap_up();
  end

  initial begin
    n_errors = 0;
    n_tests  = 0;
    seed     = 55;
    presetn  = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    quiet   = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    irq_ack = 3'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("outputs after reset", 33'h20, {27'h0, osc_pin_out, wave_out_a, wave_out_b, irq});
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 33'h0, "reset value");
    wr(8'h20, 32'hFF);
    rd(8'h20, {1'b1, 32'h0}, "unmapped read");
    // stopped counter and direct compare access
    repeat (3) begin
      for (int i = 0; i < 5; i++) begin
        v = $random(seed);
        wr(ra[i], v);
        rd(ra[i], {25'h0, v[7:0] & rm[i]}, "register readback");
      end
    end
    wr(`TMR_ADDR_ASYNC, 32'h0);
    wr(`TMR_ADDR_COUNT, 32'h77);
    repeat (50) @(posedge pclk);
    rd(`TMR_ADDR_COUNT, 33'h77, "stopped count");
    // every output mode set by force before use
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`TMR_ADDR_CTRL_A, 32'(com_seq[k]) << (ch ? 4 : 6));
        wr(`TMR_ADDR_CTRL_B, ch ? 32'h40 : 32'h80);
        repeat (2) @(posedge pclk);
        chk("forced output", {32'h0, wav_seq[k]}, {32'h0, ch ? wave_out_b : wave_out_a});
      end
    end
    rd(`TMR_ADDR_FLAG, 33'h0, "flags after force");
    wr(`TMR_ADDR_CTRL_A, 32'h43);
    wr(`TMR_ADDR_CTRL_B, 32'h80);
    repeat (2) @(posedge pclk);
    chk("output across mode change", 33'h1, {32'h0, wave_out_a});
    // compare A flag, mask and clearing
    wr(`TMR_ADDR_CTRL_A, 32'h0);
    wr(`TMR_ADDR_FLAG, 32'h7);
    wr(`TMR_ADDR_MASK, 32'h7);
    wr(`TMR_ADDR_CMP_A, 32'h14);
    wr(`TMR_ADDR_CMP_B, 32'h80);
    wr(`TMR_ADDR_COUNT, 32'h10); // count starts off compare A
    wr(`TMR_ADDR_CTRL_B, 32'h1);
    wait_irq(1);
    wr(`TMR_ADDR_CTRL_B, 32'h0);
    rd(`TMR_ADDR_FLAG, 33'h2, "match flag a");
    wr(`TMR_ADDR_FLAG, 32'h0);
    rd(`TMR_ADDR_FLAG, 33'h2, "flag after zero write");
    wr(`TMR_ADDR_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("masked irq", 33'h0, {30'h0, irq});
    wr(`TMR_ADDR_FLAG, 32'h2);
    rd(`TMR_ADDR_FLAG, 33'h0, "flag after one write");
    // overflow on wrap, cleared by service
    wr(`TMR_ADDR_MASK, 32'h7);
    wr(`TMR_ADDR_COUNT, 32'hF0);
    wr(`TMR_ADDR_CTRL_B, 32'h1);
    wait_irq(0);
    wr(`TMR_ADDR_CTRL_B, 32'h0);
    rd(`TMR_ADDR_FLAG, 33'h1, "overflow flag");
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    rd(`TMR_ADDR_FLAG, 33'h0, "flag after service");
    // first tick after a count write sees no match
    wr(`TMR_ADDR_CMP_B, 32'h30);
    wr(`TMR_ADDR_COUNT, 32'h30);
    run(10);
    rd(`TMR_ADDR_FLAG, 33'h0, "blocked match");
    // buffered compare in fast mode, loaded at top, direct in normal mode
    wr(`TMR_ADDR_CMP_B, 32'hF0);
    wr(`TMR_ADDR_CTRL_A, 32'h3);
    wr(`TMR_ADDR_CMP_B, 32'h42);
    rd(`TMR_ADDR_CMP_B, 33'h42, "compare buffer");
    wr(`TMR_ADDR_COUNT, 32'h40);
    run(12);
    rd(`TMR_ADDR_FLAG, 33'h0, "buffered compare");
    wr(`TMR_ADDR_COUNT, 32'hF8);
    run(80);
    rd(`TMR_ADDR_FLAG, 33'h7, "compare loaded at top");
    wr(`TMR_ADDR_FLAG, 32'h7);
    wr(`TMR_ADDR_CTRL_A, 32'h0);
    wr(`TMR_ADDR_CMP_B, 32'h42);
    wr(`TMR_ADDR_COUNT, 32'h40);
    run(12);
    rd(`TMR_ADDR_FLAG, 33'h4, "direct compare");
    // crystal ticks, judged by the edge assertion in the clock select
    wr(`TMR_ADDR_ASYNC, 32'h1);
    run(40);
    wr(`TMR_ADDR_ASYNC, 32'h0);
    // phase-correct turns down at top and never reaches bottom here
    wr(`TMR_ADDR_FLAG, 32'h7);
    wr(`TMR_ADDR_CTRL_A, 32'h1);
    wr(`TMR_ADDR_COUNT, 32'hFC);
    run(20);
    peek(`TMR_ADDR_COUNT, v);
    chk("count after turn", 33'h1, {32'h0, v < 32'hFC && v > 32'hD0});
    rd(`TMR_ADDR_FLAG, 33'h0, "flags in phase correct");
    // clear-on-match keeps the count at or below compare A
    wr(`TMR_ADDR_FLAG, 32'h7);
    wr(`TMR_ADDR_CTRL_A, 32'h2);
    wr(`TMR_ADDR_CMP_A, 32'h0A);
    wr(`TMR_ADDR_COUNT, 32'h0);
    run(600);
    peek(`TMR_ADDR_COUNT, v);
    chk("count bounded by top", 33'h1, {32'h0, v <= 32'h0A});
    rd(`TMR_ADDR_FLAG, 33'h2, "flags in clear-on-match");
    repeat (4) @(posedge pclk);
    chk("pending reads", 33'h0, 33'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
